// file: rtl/qcc_top.v
`timescale 1ns/1ps
`include "qcc_defines.vh"
// What this block does
// - comparator one picks primary or secondary level
// - others pick primary or external level
// - per-comparator interrupt enable gates requests
// - polarity bit inverts comparator output
// - live outputs readable by software
// - both edges detected for interrupts
// - config byte one: comparators one, two
// - config byte two: comparators three, four
// - primary 8-bit threshold code to DAC
// - secondary code also drives DAC output
// - toggle while enabled sets sticky flag
// - disabled comparator reads low
// - optional filter needs 16 stable cycles
module qcc_top (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // register port
  input wire [15:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // analog side
  input wire [3:0] cmp_raw_i,
  output wire [3:0] cmp_on_o,
  output wire [3:0] cmp_pick_ext_o,
  output wire cmp1_pick_secondary_o,
  output wire [7:0] primary_threshold_level_o,
  output wire [7:0] secondary_threshold_level_o,
  output wire dac_buffer_on_o,
  output wire settled_o,
  // interrupt
  output wire irq_o
);
  reg rst_s1;
  reg rst_s2;
  reg [7:0] cfg_ab;
  reg [7:0] cfg_cd;
  reg [7:0] primary_threshold_level;
  reg [7:0] secondary_threshold_level;
  reg dac_en;
  reg [3:0] filt_on;
  reg [3:0] flags;
  reg [3:0] imask;
  reg [3:0] on_d;
  reg [15:0] settle_cnt;
  wire [3:0] live;
  wire [3:0] edges;
  wire [3:0] on_v;
  wire [3:0] pick_v;
  wire [3:0] allow_v;
  wire [3:0] inv_v;

  function [3:0] grp;
    input [7:0] b;
    input hi;
    begin
      grp = hi ? b[7:4] : b[3:0];
    end
  endfunction

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // comparator n maps to index n-1
  wire [3:0] grp_1 = grp(cfg_ab, 1'b1);
  wire [3:0] grp_2 = grp(cfg_ab, 1'b0);
  wire [3:0] grp_3 = grp(cfg_cd, 1'b1);
  wire [3:0] grp_4 = grp(cfg_cd, 1'b0);
  assign on_v = {grp_4[`QCC_BIT_ON], grp_3[`QCC_BIT_ON],
                 grp_2[`QCC_BIT_ON], grp_1[`QCC_BIT_ON]};
  assign pick_v = {grp_4[`QCC_BIT_PICK], grp_3[`QCC_BIT_PICK],
                   grp_2[`QCC_BIT_PICK], grp_1[`QCC_BIT_PICK]};
  assign allow_v = {grp_4[`QCC_BIT_IRQ], grp_3[`QCC_BIT_IRQ],
                    grp_2[`QCC_BIT_IRQ], grp_1[`QCC_BIT_IRQ]};
  assign inv_v = {grp_4[`QCC_BIT_INV], grp_3[`QCC_BIT_INV],
                  grp_2[`QCC_BIT_INV], grp_1[`QCC_BIT_INV]};

  assign cmp_on_o = on_v;
  assign cmp1_pick_secondary_o = pick_v[0];
  assign cmp_pick_ext_o = {pick_v[3:1], 1'b0};
  assign primary_threshold_level_o = primary_threshold_level;
  assign secondary_threshold_level_o = secondary_threshold_level;
  assign dac_buffer_on_o = dac_en;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : ch
      qcc_chan u_chan (
        .clk_i(clk_i),
        .rst_n_i(rst_s2),
        .on_i(on_v[g]),
        .invert_i(inv_v[g]),
        .filter_on_i(filt_on[g]),
        .raw_i(cmp_raw_i[g]),
        .live_o(live[g]),
        .edge_o(edges[g])
      );
    end
  endgenerate

  wire wr_stat = wr_i && addr_i == `QCC_ADDR_STAT;

  always @(posedge clk_i or negedge rst_s2) begin
    if (!rst_s2) begin
      cfg_ab <= `QCC_RST_BYTE;
      cfg_cd <= `QCC_RST_BYTE;
      primary_threshold_level <= `QCC_RST_BYTE;
      secondary_threshold_level <= `QCC_RST_BYTE;
      dac_en <= 1'b0;
      filt_on <= 4'h0;
      imask <= 4'h0;
    end else if (wr_i) begin
      if (addr_i == `QCC_ADDR_CFG_AB) begin
        cfg_ab <= wdata_i;
      end else if (addr_i == `QCC_ADDR_CFG_CD) begin
        cfg_cd <= wdata_i;
      end else if (addr_i == `QCC_ADDR_PRIMARY_THRESHOLD_LEVEL) begin
        primary_threshold_level <= wdata_i;
      end else if (addr_i == `QCC_ADDR_SECONDARY_THRESHOLD_LEVEL) begin
        secondary_threshold_level <= wdata_i;
      end else if (addr_i == `QCC_ADDR_DAC) begin
        dac_en <= wdata_i[`QCC_DAC_EN_BIT];
      end else if (addr_i == `QCC_ADDR_STAT) begin
        filt_on <= wdata_i[3:0];
      end else if (addr_i == `QCC_ADDR_IMASK) begin
        imask <= wdata_i[3:0];
      end
    end
  end

  // set wins over write-one-to-clear
  always @(posedge clk_i or negedge rst_s2) begin
    if (!rst_s2) begin
      flags <= 4'h0;
    end else begin
      flags <= (flags & ~(wr_stat ? wdata_i[7:4] : 4'h0)) | edges;
    end
  end

  // gated by per-channel allow and by the mask register
  assign irq_o = |(flags & allow_v & imask);

  // settle timer restarts on any off-to-on change
  always @(posedge clk_i or negedge rst_s2) begin
    if (!rst_s2) begin
      on_d <= 4'h0;
      settle_cnt <= 16'h0000;
    end else begin
      on_d <= on_v;
      if (|(on_v & ~on_d)) begin
        settle_cnt <= `QCC_SETTLE_CYC;
      end else if (settle_cnt != 16'h0000) begin
        settle_cnt <= settle_cnt - 16'h0001;
      end
    end
  end
  assign settled_o = settle_cnt == 16'h0000;

  always @(posedge clk_i or negedge rst_s2) begin
    if (!rst_s2) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == `QCC_ADDR_CFG_AB) begin
        rdata_o <= cfg_ab;
      end else if (addr_i == `QCC_ADDR_CFG_CD) begin
        rdata_o <= cfg_cd;
      end else if (addr_i == `QCC_ADDR_PRIMARY_THRESHOLD_LEVEL) begin
        rdata_o <= primary_threshold_level;
      end else if (addr_i == `QCC_ADDR_SECONDARY_THRESHOLD_LEVEL) begin
        rdata_o <= secondary_threshold_level;
      end else if (addr_i == `QCC_ADDR_DAC) begin
        rdata_o <= {dac_en, 7'h00};
      end else if (addr_i == `QCC_ADDR_STAT) begin
        rdata_o <= {flags, live};
      end else if (addr_i == `QCC_ADDR_IMASK) begin
        rdata_o <= {4'h0, imask};
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule

// file: rtl/qcc_defines.vh
`ifndef QCC_DEFINES_VH
`define QCC_DEFINES_VH
`define QCC_AW 16
`define QCC_ADDR_CFG_AB 16'hA038
`define QCC_ADDR_CFG_CD 16'hA039
`define QCC_ADDR_PRIMARY_THRESHOLD_LEVEL 16'hA03A
`define QCC_ADDR_SECONDARY_THRESHOLD_LEVEL 16'hA03B
`define QCC_ADDR_DAC 16'hA03C
`define QCC_ADDR_STAT 16'hA03D
`define QCC_ADDR_IMASK 16'hA03E
`define QCC_RST_BYTE 8'h00
`define QCC_BIT_ON 3
`define QCC_BIT_PICK 2
`define QCC_BIT_IRQ 1
`define QCC_BIT_INV 0
`define QCC_DAC_EN_BIT 7
`define QCC_FILT_LEN 5'h10
`define QCC_SETTLE_NS 20000
`define QCC_SETTLE_CYC 16'h0320
`define QCC_CLK_NS 25
`endif

// file: rtl/qcc_chan.v
`timescale 1ns/1ps
`include "qcc_defines.vh"
module qcc_chan (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // controls
  input wire on_i,
  input wire invert_i,
  input wire filter_on_i,
  // raw comparator
  input wire raw_i,
  // results
  output reg live_o,
  output wire edge_o
);
  reg sync_a;
  reg sync_b;
  reg accepted;
  reg [4:0] stable_cnt;
  wire pol = sync_b ^ invert_i;
  wire next_live = on_i & accepted;

  // two stages; first stage only feeds the second
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= raw_i;
      sync_b <= sync_a;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      accepted <= 1'b0;
      stable_cnt <= 5'h0_0;
    end else if (!filter_on_i || pol == accepted) begin
      accepted <= pol;
      stable_cnt <= 5'h0_0;
    end else if (stable_cnt == `QCC_FILT_LEN - 5'h0_1) begin
      accepted <= pol;
      stable_cnt <= 5'h0_0;
    end else begin
      stable_cnt <= stable_cnt + 5'h0_1;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      live_o <= 1'b0;
    end else begin
      live_o <= next_live;
    end
  end

  // on for two cycles running, so switching on or off makes no edge
  reg on_q;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_q <= 1'b0;
    end else begin
      on_q <= on_i;
    end
  end

  // both directions of the live bit count as a toggle
  assign edge_o = on_i & on_q & (live_o != next_live);
endmodule

// file: sim/qcc_monitor.sv
`timescale 1ns/1ps
`include "qcc_defines.vh"
module qcc_monitor (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // register port
  input wire [15:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  // analog side
  input wire [3:0] cmp_on_o,
  input wire [3:0] cmp_pick_ext_o,
  input wire cmp1_pick_secondary_o,
  input wire [7:0] primary_threshold_level_o,
  input wire [7:0] secondary_threshold_level_o,
  input wire irq_o
);
  wire w_ab = wr_i && addr_i == `QCC_ADDR_CFG_AB;
  wire w_cd = wr_i && addr_i == `QCC_ADDR_CFG_CD;
  wire w_t0 = wr_i && addr_i == `QCC_ADDR_PRIMARY_THRESHOLD_LEVEL;
  wire w_t1 = wr_i && addr_i == `QCC_ADDR_SECONDARY_THRESHOLD_LEVEL;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  cfg_ab_a: assert property (w_ab |=>
    cmp1_pick_secondary_o == $past(wdata_i[6])
    && cmp_on_o[1:0] == {$past(wdata_i[3]), $past(wdata_i[7])})
    else $error("config ab");
  cfg_cd_a: assert property (w_cd |=>
    cmp_pick_ext_o[3:2] == {$past(wdata_i[2]), $past(wdata_i[6])})
    else $error("config cd");
  pick_one_a: assert property (cmp_pick_ext_o[0] == 1'b0)
    else $error("pick one");
  code_pri_a: assert property (w_t0 |=>
    primary_threshold_level_o == $past(wdata_i)) else $error("code 0");
  code_sec_a: assert property (w_t1 |=>
    secondary_threshold_level_o == $past(wdata_i)) else $error("code 1");
  read_pri_a: assert property (rd_i && addr_i == `QCC_ADDR_PRIMARY_THRESHOLD_LEVEL
    |=> rdata_o == $past(primary_threshold_level_o)) else $error("rd 0");
  dark_live_a: assert property ((cmp_on_o == 4'h0)[*6]
    ##0 rd_i && addr_i == `QCC_ADDR_STAT |=> rdata_o[3:0] == 4'h0)
    else $error("dark live");
  irq_cause_a: assert property ($rose(irq_o) |->
    $past(cmp_on_o) != 4'h0 || $past(wr_i)) else $error("irq cause");
endmodule
bind qcc_top qcc_monitor qcc_monitor_i (.*);

// file: sim/qcc_analog.sv
`timescale 1ns/1ps
module qcc_analog (
  input wire clk_i,
  input wire [3:0] on_i,
  input wire [3:0] ext_i,
  input wire sec_i,
  input wire [7:0] pri_i,
  input wire [7:0] secl_i,
  input wire [7:0] extl_i,
  input wire [31:0] vin_i,
  output reg [3:0] raw_o
);
  integer k;
  reg [7:0] thr;
  initial raw_o = 4'h0;
  always @(posedge clk_i) begin
    for (k = 0; k < 4; k = k + 1) begin
      thr = ext_i[k] ? extl_i : pri_i;
      if (k == 0 && sec_i) thr = secl_i;
      // an unpowered comparator gives no steady answer
      raw_o[k] <= on_i[k] ? vin_i[8*k +: 8] > thr : ~raw_o[k];
    end
  end
endmodule

// file: sim/qcc_top_bench.sv
`timescale 1ns/1ps
`include "qcc_defines.vh"
`define CHK(a, b) begin n_tests = n_tests + 1; if ((a) !== (b)) begin \
  n_fail = n_fail + 1; $display("mismatch %0t value differs", $time); end end
module qcc_top_bench;
  reg clk_i, rst_n_i, wr_i, rd_i;
  reg [15:0] addr_i;
  reg [7:0] wdata_i, ext, q, ab, cd;
  reg [31:0] vin;
  wire [7:0] rdata_o, pri, sec;
  wire [3:0] raw, on, pex;
  wire psec, irq, dac, setl;
  integer n_fail, n_tests, seed, i;
  qcc_top qcc_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cmp_raw_i(raw), .cmp_on_o(on), .cmp_pick_ext_o(pex),
    .cmp1_pick_secondary_o(psec), .primary_threshold_level_o(pri),
    .secondary_threshold_level_o(sec), .dac_buffer_on_o(dac),
    .settled_o(setl), .irq_o(irq));
  qcc_analog qcc_analog_i (.clk_i(clk_i), .on_i(on), .ext_i(pex),
    .sec_i(psec), .pri_i(pri), .secl_i(sec), .extl_i(ext), .vin_i(vin),
    .raw_o(raw));
  function [3:0] live(input [7:0] a, input [7:0] c, input hi);
    live = {c[0], c[4], a[0], a[4]} ^ {4{hi}};
  endfunction
  task wr(input [15:0] a, input [7:0] d);
    begin
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task rd(input [15:0] a);
    begin
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 q = rdata_o;
      @(posedge clk_i);
    end
  endtask
  task conclude;
    begin
      if (n_fail == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    seed = 14; n_fail = 0; n_tests = 0; rst_n_i = 0; wr_i = 0; rd_i = 0;
    addr_i = 0; wdata_i = 0; ext = $random(seed) & 8'hFE; vin = 0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (i = 0; i < 7; i = i + 1) begin
      rd(16'hA038 + i);
      `CHK(q, 8'h00)
    end
    rd(16'hA040);
    `CHK(q, 8'h00)
    for (i = 0; i < 8; i = i + 1) begin
      ab = $random(seed);
      wr(16'hA038 + (i & 3), ab);
      rd(16'hA038 + (i & 3));
      `CHK(q, ab)
    end
    wr(`QCC_ADDR_DAC, 8'h80);
    `CHK(dac, 1'b1)
    wr(`QCC_ADDR_CFG_AB, 8'h00);
    ab = $random(seed) | 8'hAA;
    cd = $random(seed) | 8'hAA;
    wr(`QCC_ADDR_CFG_AB, ab);
    wr(`QCC_ADDR_CFG_CD, cd);
    wr(`QCC_ADDR_PRIMARY_THRESHOLD_LEVEL, $random(seed) & 8'hFE);
    wr(`QCC_ADDR_SECONDARY_THRESHOLD_LEVEL, $random(seed) & 8'hFE);
    wr(`QCC_ADDR_IMASK, 8'h0F);
    `CHK(setl, 1'b0)
    repeat (820) @(posedge clk_i);
    `CHK(setl, 1'b1)
    wr(`QCC_ADDR_STAT, 8'hF0);
    rd(`QCC_ADDR_STAT);
    `CHK(q, {4'h0, live(ab, cd, 1'b0)})
    `CHK(irq, 1'b0)
    vin <= 32'hFFFF_FFFF;
    repeat (8) @(posedge clk_i);
    rd(`QCC_ADDR_STAT);
    `CHK(q, {4'hF, live(ab, cd, 1'b1)})
    `CHK(irq, 1'b1)
    wr(`QCC_ADDR_STAT, 8'hF0);
    vin <= 32'h0000_0000;
    repeat (8) @(posedge clk_i);
    rd(`QCC_ADDR_STAT);
    `CHK(q, {4'hF, live(ab, cd, 1'b0)})
    wr(`QCC_ADDR_STAT, 8'hF0);
    wr(`QCC_ADDR_CFG_AB, ab & 8'hDD);
    wr(`QCC_ADDR_CFG_CD, cd & 8'hDD);
    `CHK(irq, 1'b0)
    vin <= 32'hFFFF_FFFF;
    repeat (8) @(posedge clk_i);
    rd(`QCC_ADDR_STAT);
    `CHK(q[7:4], 4'hF)
    `CHK(irq, 1'b0)
    wr(`QCC_ADDR_CFG_AB, 8'h00);
    wr(`QCC_ADDR_CFG_CD, 8'h00);
    wr(`QCC_ADDR_PRIMARY_THRESHOLD_LEVEL, 8'h00);
    wr(`QCC_ADDR_SECONDARY_THRESHOLD_LEVEL, 8'h00);
    rd(`QCC_ADDR_STAT);
    `CHK(q[3:0], 4'h0)
    conclude;
  end
endmodule
